// [src/i2c_slave_pkg.sv]
// constants and carrier types for the two-wire slave interface
// assumes one system clock; register port is a plain strobe port
package i2c_slave_pkg;
   localparam int unsigned REG_AW = 3;
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_OWN  = 3'h1;
   localparam logic [2:0] OFS_CTL0 = 3'h2;
   localparam logic [2:0] OFS_CTL1 = 3'h3;
   // enable_debounce_control fields
   localparam int unsigned CTL0_DEB = 2;
   localparam int unsigned CTL0_EN  = 1;
   // bus_status_control fields
   localparam int unsigned CTL1_HCF  = 7;
   localparam int unsigned CTL1_ADDRESS_MATCH_FLAG = 6;
   localparam int unsigned CTL1_BUSY = 5;
   localparam int unsigned CTL1_HTX  = 4;
   localparam int unsigned CTL1_TRANSMIT_ACK_CONTROL = 3;
   localparam int unsigned CTL1_SRW  = 2;
   localparam int unsigned CTL1_WAKE = 1;
   localparam int unsigned CTL1_RECEIVED_ACK_FLAG = 0;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] OWN_RST  = 8'h00;
   localparam logic [7:0] CTL0_RST = 8'h00;
   localparam logic [7:0] CTL1_RST = 8'h81;
   // debounce lengths in system clocks
   localparam logic [2:0] DEB_SHORT = 3'h2;
   localparam logic [2:0] DEB_LONG  = 3'h4;
   localparam logic [2:0] BIT_LAST  = 3'h7;
   localparam logic       LINE_IDLE = 1'b1;

   typedef struct packed {
      logic             wr;
      logic             rd;
      logic [REG_AW-1:0] addr;
      logic [7:0]       wdata;
   } reg_req_type;

   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } line_drive_type;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_HIT, ST_ADDR_ACK, ST_STRETCH, ST_RX_BYTE,
      ST_RX_DONE, ST_RX_ACK, ST_TX_BYTE, ST_TX_ACK, ST_WAIT_STOP
   } slave_state_type;
endpackage : i2c_slave_pkg

// [src/line_sync.sv]
// two-flop synchroniser for one bus line
// assumes the line idles high through its pull-up
`timescale 1ns/1ps
module line_sync (
   input  wire logic ref_clk_i,
   input  wire logic resetn_i,
   input  wire logic clk_en_i,
   input  wire logic line_i,
   output logic      line_o
);
   import i2c_slave_pkg::*;
   logic meta;

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         meta   <= LINE_IDLE;
         line_o <= LINE_IDLE;
      end else if (clk_en_i) begin
         meta   <= line_i;
         line_o <= meta;
      end
   end
endmodule : line_sync

// [src/line_debounce.sv]
// glitch filter: output follows input once it held for the chosen length
// assumes a synchronised input; a zero length means pass-through
`timescale 1ns/1ps
module line_debounce (
   input  wire logic       ref_clk_i,
   input  wire logic       resetn_i,
   input  wire logic       clk_en_i,
   input  wire logic       line_i,
   input  wire logic [2:0] len_i,
   output logic            line_o
);
   import i2c_slave_pkg::*;
   logic [2:0] cnt;

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         line_o <= LINE_IDLE;
         cnt    <= 3'h0;
      end else if (clk_en_i) begin
         if (line_i == line_o) begin
            cnt <= 3'h0;
         end else if (len_i == 3'h0 || cnt == len_i - 3'h1) begin
            line_o <= line_i;
            cnt    <= 3'h0;
         end else begin
            cnt <= cnt + 3'h1;
         end
      end
   end
endmodule : line_debounce

// [src/i2c_slave_if.sv]
// slave-only two-wire serial interface with register port
// assumes open-drain lines resolved outside; scl/sda arrive asynchronously
// Summary of operation
// RQ1: all bytes pass through one 8-bit data buffer register
// RQ2: own address holds 7-bit address in bits 7..1, bit 0 unused
// RQ3: device is selected when received address equals own address
// RQ4: address-match flag shows whether last address equalled own address
// RQ5: debounce select 00 none, 01 two clocks, 1x four clocks
// RQ6: debounce acts only on high-speed clock or wake control clear
// RQ7: interface disabled means lines released and logic idle
// RQ8: enabling keeps direction and ack bits, resets status flags
// RQ9: completion flag low while shifting, high plus interrupt after byte
// RQ10: busy flag set on START, cleared on STOP
// RQ11: direction bit 0 receive, 1 transmit
// RQ12: after received byte, ack control bit driven on ninth clock
// RQ13: software keeps ack control at 0 before receiving more
// RQ14: eighth bit after address captured as read/write flag
// RQ15: wake control lets address match wake; software clears it
// RQ16: received-ack flag is master's ninth bit after transmitted byte
// RQ17: transmitter continues on ack, releases SDA on no-ack
// RQ18: seven address bits taken MSB first after START
// RQ19: address match sets match flag and raises interrupt
// RQ20: software tells interrupt sources apart by flags
// RQ21: software enables, writes address, then enables interrupt
// RQ22: START is SDA falling with SCL high; slave never makes it
// RQ23: unimplemented register bits read as zero
// RQ24: SCL held low after match until data write or dummy read
// RQ25: address match acknowledged by low SDA on ninth bit
// RQ26: bytes are 8 bits, MSB first
// RQ27: STOP is SDA rising with SCL high, ends transaction
// RQ28: writable bits read back; read-only flags ignore writes
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module i2c_slave_if (
   input  wire logic                        ref_clk_i,
   input  wire logic                        resetn_i,
   input  wire logic                        clk_en_i,
   input  wire i2c_slave_pkg::reg_req_type  reg_req_i,
   output logic [7:0]                       rdata_o,
   input  wire logic                        scl_i,
   input  wire logic                        sda_i,
   input  wire logic                        sysclk_from_fast_i,
   output i2c_slave_pkg::line_drive_type    line_drive_o,
   output logic                             irq_o,
   output logic                             wake_o
);
   import i2c_slave_pkg::*;

   logic [7:0]      data_buffer;
   logic [7:1]      own_addr;
   logic [1:0]      debounce_select;
   logic            interface_enable;
   logic            transmit_direction;
   logic            transmit_ack_control;
   logic            match_wake_enable;
   logic            transfer_complete_flag;
   logic            address_match_flag;
   logic            bus_busy_flag;
   logic            read_write_captured;
   logic            received_ack_flag;
   slave_state_type state;
   logic [2:0]      cnt;
   logic [7:0]      shift;
   logic            scl_s, sda_s, scl_f, sda_f, scl_d, sda_d;
   logic [2:0]      deb_len;
   logic            scl_rise, scl_fall, start_det, stop_det;
   logic            addr_done, matched, rx_done, tx_ack_smp;
   logic            tx_go, rx_go, byte_start;
   logic            wr_data, rd_data;

   assign wr_data = reg_req_i.wr && reg_req_i.addr == OFS_DATA;
   assign rd_data = reg_req_i.rd && reg_req_i.addr == OFS_DATA;

   // both lines get the same filter so START/STOP see aligned edges
   assign deb_len = (!sysclk_from_fast_i && match_wake_enable) ? 3'h0 : // RQ6
                    debounce_select[1] ? DEB_LONG :                     // RQ5
                    debounce_select[0] ? DEB_SHORT : 3'h0;

   line_sync u_scl_sync (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .clk_en_i  (clk_en_i),
      .line_i    (scl_i),
      .line_o    (scl_s)
   );
   line_sync u_sda_sync (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .clk_en_i  (clk_en_i),
      .line_i    (sda_i),
      .line_o    (sda_s)
   );
   line_debounce u_scl_deb (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .clk_en_i  (clk_en_i),
      .line_i    (scl_s),
      .len_i     (deb_len),
      .line_o    (scl_f)
   );
   line_debounce u_sda_deb (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .clk_en_i  (clk_en_i),
      .line_i    (sda_s),
      .len_i     (deb_len),
      .line_o    (sda_f)
   );

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         scl_d <= LINE_IDLE;
         sda_d <= LINE_IDLE;
      end else if (clk_en_i) begin
         scl_d <= scl_f;
         sda_d <= sda_f;
      end
   end

   assign scl_rise   = interface_enable && scl_f && !scl_d;
   assign scl_fall   = interface_enable && !scl_f && scl_d;
   assign start_det  = interface_enable && scl_f && scl_d && sda_d && !sda_f; // RQ22
   assign stop_det   = interface_enable && scl_f && scl_d && !sda_d && sda_f; // RQ27
   assign matched    = shift[6:0] == own_addr;                                // RQ3
   assign addr_done  = state == ST_ADDR && scl_rise && cnt == BIT_LAST;
   assign rx_done    = state == ST_RX_BYTE && scl_rise && cnt == BIT_LAST;
   assign tx_ack_smp = state == ST_TX_ACK && scl_rise;
   assign tx_go      = state == ST_STRETCH && transmit_direction && wr_data;   // RQ24
   assign rx_go      = state == ST_STRETCH && !transmit_direction && rd_data;  // RQ24
   assign byte_start = tx_go || rx_go;

   // software-owned control bits; enabling leaves direction and ack alone
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         own_addr             <= OWN_RST[7:1];
         debounce_select      <= CTL0_RST[CTL0_DEB+:2];
         interface_enable     <= CTL0_RST[CTL0_EN];
         transmit_direction   <= CTL1_RST[CTL1_HTX];
         transmit_ack_control <= CTL1_RST[CTL1_TRANSMIT_ACK_CONTROL];
         match_wake_enable    <= CTL1_RST[CTL1_WAKE];
      end else if (clk_en_i && reg_req_i.wr) begin
         if (reg_req_i.addr == OFS_OWN) begin
            own_addr <= reg_req_i.wdata[7:1]; // RQ2
         end
         if (reg_req_i.addr == OFS_CTL0) begin
            debounce_select  <= reg_req_i.wdata[CTL0_DEB+:2];
            interface_enable <= reg_req_i.wdata[CTL0_EN];
         end
         if (reg_req_i.addr == OFS_CTL1) begin // RQ28
            transmit_direction   <= reg_req_i.wdata[CTL1_HTX]; // RQ11
            transmit_ack_control <= reg_req_i.wdata[CTL1_TRANSMIT_ACK_CONTROL];
            match_wake_enable    <= reg_req_i.wdata[CTL1_WAKE];
         end
      end
   end

   // received byte lands in the same buffer software preloads
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         data_buffer <= DATA_RST;
      end else if (clk_en_i) begin
         if (rx_done) begin
            data_buffer <= {shift[6:0], sda_f}; // RQ1
         end else if (wr_data) begin
            data_buffer <= reg_req_i.wdata;     // RQ1
         end
      end
   end

   // status flags: hardware sets win over hardware clears
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         transfer_complete_flag <= CTL1_RST[CTL1_HCF];
         address_match_flag     <= CTL1_RST[CTL1_ADDRESS_MATCH_FLAG];
         bus_busy_flag          <= CTL1_RST[CTL1_BUSY];
         read_write_captured    <= CTL1_RST[CTL1_SRW];
         received_ack_flag      <= CTL1_RST[CTL1_RECEIVED_ACK_FLAG];
      end else if (clk_en_i) begin
         if (!interface_enable) begin // RQ8
            transfer_complete_flag <= CTL1_RST[CTL1_HCF];
            address_match_flag     <= CTL1_RST[CTL1_ADDRESS_MATCH_FLAG];
            bus_busy_flag          <= CTL1_RST[CTL1_BUSY];
            read_write_captured    <= CTL1_RST[CTL1_SRW];
            received_ack_flag      <= CTL1_RST[CTL1_RECEIVED_ACK_FLAG];
         end else begin
            if (start_det) begin
               bus_busy_flag <= 1'b1; // RQ10
            end else if (stop_det) begin
               bus_busy_flag <= 1'b0; // RQ10
            end
            if (addr_done) begin
               address_match_flag <= matched; // RQ4
            end
            if (addr_done && matched) begin
               read_write_captured <= sda_f; // RQ14
            end
            if ((addr_done && matched) || rx_done || tx_ack_smp) begin
               transfer_complete_flag <= 1'b1; // RQ9
            end else if (byte_start || start_det) begin
               transfer_complete_flag <= 1'b0; // RQ9
            end
            if (tx_ack_smp) begin
               received_ack_flag <= sda_f; // RQ16
            end
         end
      end
   end

   // bit engine: sample on SCL rise, change SDA only while SCL is low
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         state        <= ST_IDLE;
         cnt          <= 3'h0;
         shift        <= 8'h00;
         line_drive_o <= '0;
      end else if (clk_en_i) begin
         if (!interface_enable || stop_det) begin // RQ7 RQ27
            state        <= ST_IDLE;
            line_drive_o <= '0;
         end else if (start_det) begin
            state        <= ST_ADDR;
            cnt          <= 3'h0;
            line_drive_o <= '0;
         end else begin
            case (state)
               ST_ADDR: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_f}; // RQ18
                     cnt   <= cnt + 3'h1;
                     if (cnt == BIT_LAST) begin
                        state <= matched ? ST_ADDR_HIT : ST_WAIT_STOP; // RQ3
                     end
                  end
               end
               ST_ADDR_HIT: begin
                  if (scl_fall) begin
                     line_drive_o.sda_oe <= 1'b1; // RQ25
                     state               <= ST_ADDR_ACK;
                  end
               end
               ST_ADDR_ACK, ST_RX_ACK: begin
                  if (scl_fall) begin
                     line_drive_o.sda_oe <= 1'b0;
                     line_drive_o.scl_oe <= 1'b1; // RQ24
                     state               <= ST_STRETCH;
                  end
               end
               ST_STRETCH: begin
                  if (tx_go) begin
                     shift               <= reg_req_i.wdata;
                     line_drive_o.sda_oe <= !reg_req_i.wdata[7]; // RQ26
                     line_drive_o.scl_oe <= 1'b0;
                     cnt                 <= 3'h0;
                     state               <= ST_TX_BYTE;
                  end else if (rx_go) begin
                     line_drive_o.scl_oe <= 1'b0;
                     cnt                 <= 3'h0;
                     state               <= ST_RX_BYTE;
                  end
               end
               ST_RX_BYTE: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_f}; // RQ26
                     cnt   <= cnt + 3'h1;
                     if (cnt == BIT_LAST) begin
                        state <= ST_RX_DONE;
                     end
                  end
               end
               ST_RX_DONE: begin
                  if (scl_fall) begin
                     line_drive_o.sda_oe <= !transmit_ack_control; // RQ12
                     state               <= ST_RX_ACK;
                  end
               end
               ST_TX_BYTE: begin
                  if (scl_fall) begin
                     if (cnt == BIT_LAST) begin
                        line_drive_o.sda_oe <= 1'b0;
                        state               <= ST_TX_ACK;
                     end else begin
                        shift               <= {shift[6:0], 1'b0};
                        line_drive_o.sda_oe <= !shift[6]; // RQ26
                        cnt                 <= cnt + 3'h1;
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (scl_fall) begin
                     if (received_ack_flag) begin
                        state <= ST_WAIT_STOP; // RQ17
                     end else begin
                        line_drive_o.scl_oe <= 1'b1; // RQ17
                        state               <= ST_STRETCH;
                     end
                  end
               end
               ST_IDLE, ST_WAIT_STOP: begin
                  state <= state;
               end
               default: begin
                  state        <= ST_IDLE;
                  line_drive_o <= '0;
               end
            endcase
         end
      end
   end

   // one interrupt line shared by match and byte completion
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         irq_o  <= 1'b0;
         wake_o <= 1'b0;
      end else if (clk_en_i) begin
         irq_o  <= (addr_done && matched) || rx_done || tx_ack_smp; // RQ9 RQ19
         wake_o <= addr_done && matched && match_wake_enable;       // RQ15
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         rdata_o <= 8'h00;
      end else if (clk_en_i) begin
         rdata_o <= 8'h00;
         if (reg_req_i.rd) begin
            case (reg_req_i.addr)
               OFS_DATA: rdata_o <= data_buffer;
               OFS_OWN:  rdata_o <= {own_addr, 1'b0};                              // RQ23
               OFS_CTL0: rdata_o <= {4'h0, debounce_select, interface_enable, 1'b0}; // RQ23
               OFS_CTL1: rdata_o <= {transfer_complete_flag, address_match_flag, bus_busy_flag,
                                     transmit_direction, transmit_ack_control, read_write_captured,
                                     match_wake_enable, received_ack_flag};
               default:  rdata_o <= 8'h00;
            endcase
         end
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i || !clk_en_i);

   busy_set_a: assert property (start_det |=> bus_busy_flag) else $error("busy not set"); // RQ10
   busy_clr_a: assert property (stop_det |=> !bus_busy_flag) else $error("busy not cleared"); // RQ10
   match_flag_a: assert property (addr_done |=> address_match_flag == $past(matched)) // RQ4
      else $error("match flag wrong");
   match_irq_a: assert property (addr_done && matched |=> irq_o && transfer_complete_flag) // RQ19
      else $error("match irq missing");
   shift_hcf_a: assert property (state inside {ST_RX_BYTE, ST_TX_BYTE} |-> !transfer_complete_flag) // RQ9
      else $error("hcf high while shifting");
   addr_ack_a: assert property (state == ST_ADDR_ACK |-> line_drive_o.sda_oe) // RQ25
      else $error("address not acked");
   rx_ack_a: assert property (state == ST_RX_ACK |-> line_drive_o.sda_oe == !transmit_ack_control) // RQ12
      else $error("rx ack wrong");
   stretch_a: assert property (state == ST_STRETCH |-> line_drive_o.scl_oe) // RQ24
      else $error("scl not held");
   nack_rel_a: assert property (state == ST_WAIT_STOP |-> !line_drive_o.sda_oe) // RQ17
      else $error("sda not released");
   off_idle_a: assert property (!interface_enable ##1 !interface_enable |-> line_drive_o == '0) // RQ7
      else $error("lines driven while off");
   ctl0_read_a: assert property ( // RQ23
      reg_req_i.rd && reg_req_i.addr == OFS_CTL0 |=> rdata_o[7:4] == 4'h0 && !rdata_o[0])
      else $error("reserved bits nonzero");

   match_c: cover property (addr_done && matched);
   rx_byte_c: cover property (rx_done);
   tx_nack_c: cover property (tx_ack_smp && sda_f);
endmodule : i2c_slave_if

// [tb/i2c_master_model.sv]
// two-wire bus master model, open-drain levels (1 = released)
// assumes the bench resolves both lines with pull-ups
`timescale 1ns/1ps
module i2c_master_model (
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o,
   output logic      hung_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      hung_o = 1'b0;
   end
   // a stretching slave may hold scl low; bounded so a stuck line ends the run
   task automatic rise;
      int n;
      scl_o = 1'b1;
      n = 0;
      while (scl_i !== 1'b1 && n < 400) begin
         #50;
         n++;
      end
      if (n >= 400) hung_o = 1'b1;
   endtask : rise
   task automatic start_cond;
      sda_o = 1'b0;
      #200;
      scl_o = 1'b0;
      #100;
   endtask : start_cond
   task automatic stop_cond;
      sda_o = 1'b0;
      #100;
      rise();
      #200;
      sda_o = 1'b1;
      #200;
   endtask : stop_cond
   // data changes early in a long low phase: the slave needs about five
   // system clocks after a fall before its own data bit is on the line
   task automatic bit_io(input logic b, output logic r);
      sda_o = b;
      #300;
      rise();
      #190;
      r = sda_i;
      #10;
      scl_o = 1'b0;
      #100;
   endtask : bit_io
   task automatic xfer(input logic [7:0] d, input logic ack_i, output logic [7:0] q, output logic ack_o);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ack_i, ack_o);
   endtask : xfer
endmodule : i2c_master_model

// [tb/i2c_slave_if_tb_top.sv]
// self-checking bench for the two-wire slave interface
// assumes the master model beside it; both lines pulled up here
`timescale 1ns/1ps
module i2c_slave_if_tb_top;
   import i2c_slave_pkg::*;
   logic           ref_clk_i;
   logic           resetn_i;
   reg_req_type    req;
   logic [7:0]     rdata;
   line_drive_type drv;
   logic           irq;
   logic           wake;
   logic [7:0]     wake_cnt = 8'h00;
   logic           m_scl;
   logic           m_sda;
   logic           hung;
   wire logic      scl_w = m_scl & ~drv.scl_oe;
   wire logic      sda_w = m_sda & ~drv.sda_oe;
   int             num_errors = 0;
   int             samples_checked = 0;
   logic [7:0]     irq_cnt = 8'h00;
   logic [7:0]     d;
   logic           a;

   i2c_slave_if i_i2c_slave_if (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1), .reg_req_i(req),
      .rdata_o(rdata), .scl_i(scl_w), .sda_i(sda_w), .sysclk_from_fast_i(1'b1), .line_drive_o(drv),
      .irq_o(irq), .wake_o(wake));
   i2c_master_model m (.scl_i(scl_w), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda), .hung_o(hung));

   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) if (irq === 1'b1) irq_cnt <= irq_cnt + 8'h01;
   always @(posedge ref_clk_i) if (wake === 1'b1) wake_cnt <= wake_cnt + 8'h01;
   always @(posedge hung) begin
      num_errors++;
      close_out();
   end
   initial begin
      #1000000;
      num_errors++;
      close_out();
   end

   task automatic close_out;
      $display("errors %0d checked %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask : chk_bit
   task automatic reg_wr(input logic [2:0] ad, input logic [7:0] wd);
      @(posedge ref_clk_i);
      req <= '{1'b1, 1'b0, ad, wd};
      @(posedge ref_clk_i);
      req <= '0;
   endtask : reg_wr
   task automatic reg_rd(input logic [2:0] ad, output logic [7:0] rd);
      @(posedge ref_clk_i);
      req <= '{1'b0, 1'b1, ad, 8'h00};
      @(posedge ref_clk_i);
      req <= '0;
      #1;
      rd = rdata;
   endtask : reg_rd
   task automatic reg_chk(input logic [2:0] ad, input logic [7:0] exp);
      logic [7:0] v;
      reg_rd(ad, v);
      chk_byte(v, exp);
   endtask : reg_chk
   // the slave pulls scl low after the ninth bit of a matched address or of any received byte, and after a sent byte the master acks
   task automatic wait_stretch;
      int n;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (drv.scl_oe !== 1'b1 && n < 100);
      chk_bit(drv.scl_oe, 1'b1);
      if (n >= 100) close_out();
   endtask : wait_stretch

   initial begin
      req = '0;
      resetn_i = 1'b0;
      repeat (5) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      reg_chk(OFS_DATA, 8'h00);
      reg_chk(OFS_OWN, 8'h00);
      reg_chk(OFS_CTL0, 8'h00);
      reg_chk(OFS_CTL1, 8'h81);
      reg_chk(3'h5, 8'h00);
      reg_wr(OFS_CTL1, 8'hFF);
      reg_chk(OFS_CTL1, 8'h9B);
      reg_wr(OFS_CTL1, 8'h00);
      reg_wr(OFS_CTL0, 8'hFF);
      reg_chk(OFS_CTL0, 8'h0E);
      reg_wr(OFS_CTL0, 8'h06);
      reg_wr(OFS_OWN, 8'hA5);
      reg_chk(OFS_OWN, 8'hA4);
      m.start_cond();
      m.xfer(8'h66, 1'b1, d, a);
      chk_bit(a, 1'b1);
      m.stop_cond();
      reg_rd(OFS_CTL1, d);
      chk_bit(d[6], 1'b0);
      m.start_cond();
      reg_rd(OFS_CTL1, d);
      chk_bit(d[5], 1'b1);
      m.xfer(8'hA4, 1'b1, d, a);
      chk_bit(a, 1'b0);
      wait_stretch();
      reg_chk(OFS_CTL1, 8'hE1);
      reg_rd(OFS_DATA, d);
      m.xfer(8'h3C, 1'b1, d, a);
      chk_bit(a, 1'b0);
      wait_stretch();
      reg_wr(OFS_CTL1, 8'h08);
      reg_chk(OFS_DATA, 8'h3C);
      m.xfer(8'hC3, 1'b1, d, a);
      chk_bit(a, 1'b1);
      wait_stretch();
      reg_rd(OFS_CTL1, d);
      chk_bit(d[7], 1'b1);
      reg_chk(OFS_DATA, 8'hC3);
      m.stop_cond();
      reg_rd(OFS_CTL1, d);
      chk_bit(d[5], 1'b0);
      reg_wr(OFS_CTL1, 8'h02);
      reg_wr(OFS_CTL0, 8'h02);
      m.start_cond();
      m.xfer(8'hA5, 1'b1, d, a);
      chk_bit(a, 1'b0);
      wait_stretch();
      reg_chk(OFS_CTL1, 8'hE7);
      reg_wr(OFS_CTL1, 8'h10);
      reg_wr(OFS_DATA, 8'h96);
      m.xfer(8'hFF, 1'b0, d, a);
      chk_byte(d, 8'h96);
      wait_stretch();
      reg_rd(OFS_CTL1, d);
      chk_bit(d[0], 1'b0);
      reg_wr(OFS_DATA, 8'h5A);
      m.xfer(8'hFF, 1'b1, d, a);
      chk_byte(d, 8'h5A);
      repeat (8) @(posedge ref_clk_i);
      chk_byte({6'h00, drv.sda_oe, drv.scl_oe}, 8'h00);
      reg_rd(OFS_CTL1, d);
      chk_bit(d[0], 1'b1);
      m.stop_cond();
      reg_wr(OFS_CTL0, 8'h00);
      reg_chk(OFS_CTL1, 8'h91);
      m.start_cond();
      m.xfer(8'hA4, 1'b1, d, a);
      chk_bit(a, 1'b1);
      m.stop_cond();
      reg_wr(OFS_CTL0, 8'h02);
      reg_chk(OFS_CTL1, 8'h91);
      chk_byte(irq_cnt, 8'h06);
      chk_byte(wake_cnt, 8'h01);
      close_out();
   end
endmodule : i2c_slave_if_tb_top
